// ==== design/tzfl_pkg.sv ====
// Purpose: Constants for the trip flag latch block
// Assumes: APB, 32-bit data, one word per register
// Notes:   Register indices are word indices; byte address is index times four
//
// Function
// R1 - Summary bits 6..3 latch compare events B2, B1, A2, A1.
// R2 - Summary bit 2 sets on any one-shot trip source.
// R3 - Summary bit 1 sets on any cycle-by-cycle source, stays until cleared.
// R4 - Clearing bit 1 while a cycle trip persists sets it again at once.
// R5 - Cycle latch releases at counter zero only if no trip is present.
// R6 - Cycle latch releases only at the release point, whenever software cleared.
// R7 - Summary bit 0 sets when a trip generates the interrupt.
// R8 - No further interrupt pulses while the interrupt flag is set.
// R9 - Clearing interrupt flag with one-shot or cycle flag set pulses again.
// R10 - With every flag cleared no interrupt arises until a new trip.
// R11 - Cycle source register: sources in 5..0, A2 bit 6, B2 bit 7.
// R12 - One-shot source register: sources in 5..0, A1 bit 6, B1 bit 7.
// R13 - Flag registers read-only; cleared only through separate clear registers.
// R14 - Summary clear: write 1 clears, write 0 nothing, reads as 0. Here a read returns the release select field in bits 15..14.
// R15 - Two-bit field picks release: zero, period, either, never.
// R16 - Cycle source clear: write 1 clears matching source flag, 0 ignored.
// R17 - Trips raise the interrupt only when their enable bit is set.
// R18 - Interrupt output is one cycle, on the flag's 0 to 1 edge.

package tzfl_pkg;

  localparam int ADDR_W = 12;

  // Word indices
  localparam logic [9:0] IDX_TRIP_ENABLE   = 10'h08d;
  localparam logic [9:0] IDX_SOURCE_SELECT = 10'h090;
  localparam logic [9:0] IDX_SUMMARY_FLAGS = 10'h093;
  localparam logic [9:0] IDX_CYCLE_FLAGS   = 10'h094;
  localparam logic [9:0] IDX_SINGLE_FLAGS  = 10'h095;
  localparam logic [9:0] IDX_SUMMARY_CLEAR = 10'h097;
  localparam logic [9:0] IDX_CYCLE_CLEAR   = 10'h098;
  localparam logic [9:0] IDX_SINGLE_CLEAR  = 10'h099;

  // Summary flag layout
  localparam int SUM_INT  = 0;
  localparam int SUM_CBC  = 1;
  localparam int SUM_OST  = 2;
  localparam int SUM_DCA1 = 3;
  localparam int SUM_DCA2 = 4;
  localparam int SUM_DCB1 = 5;
  localparam int SUM_DCB2 = 6;
  localparam int SUM_W    = 7;

  // Per-source layout
  localparam int SRC_N    = 6;
  localparam int SRC_DCA  = 6;
  localparam int SRC_DCB  = 7;
  localparam int SRC_W    = 8;

  // Release select field in the summary clear register
  localparam int REL_LSB  = 14;
  localparam int REL_MSB  = 15;
  localparam logic [1:0] REL_ZERO   = 2'h0;
  localparam logic [1:0] REL_PERIOD = 2'h1;
  localparam logic [1:0] REL_EITHER = 2'h2;
  localparam logic [1:0] REL_NEVER  = 2'h3;

  // Source select layout
  localparam int SEL_DCA1_OST = 0;
  localparam int SEL_DCB1_OST = 1;
  localparam int SEL_DCA2_CBC = 2;
  localparam int SEL_DCB2_CBC = 3;
  localparam int SEL_W        = 4;

  // Reset values
  localparam logic [SUM_W-1:0] RST_ENABLE  = 7'h00;
  localparam logic [SEL_W-1:0] RST_SELECT  = 4'h0;
  localparam logic [1:0]       RST_RELEASE = 2'h0;
  localparam logic [31:0]      RST_RDATA   = 32'h0000_0000;

endpackage

// ==== design/tzfl_sticky.sv ====
// Purpose: Vector of sticky flags, set wins over clear
// Assumes: Set and clear are one-cycle or level qualifiers
// Notes:   Frozen while clk_en is low

`timescale 1ns/100ps
`default_nettype none

module tzfl_sticky #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] flags
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags[i] <= 1'b0;
        end else if (clk_en) begin
          // An event in the clearing cycle is kept
          if (set_in[i]) begin
            flags[i] <= 1'b1;
          end else if (clr_in[i]) begin
            flags[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ==== design/tzfl_top.sv ====
// Purpose: Trip flag latches with interrupt flag and APB register access
// Assumes: Trip inputs and counter events synchronous to pclk
// Notes:   Zero-wait APB; read data is registered in the setup cycle

`timescale 1ns/100ps
`default_nettype none

module tzfl_top
  import tzfl_pkg::*;
#(
  parameter int SOURCES = SRC_N
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Trip sources, high while tripping
  input  wire logic [SOURCES-1:0] cycle_by_cycle_trip,
  input  wire logic [SOURCES-1:0] one_shot_trip,
  input  wire logic               compare_a_event_one,
  input  wire logic               compare_a_event_two,
  input  wire logic               compare_b_event_one,
  input  wire logic               compare_b_event_two,
  // Time-base counter events
  input  wire logic               ctr_zero,
  input  wire logic               ctr_period,
  // Results
  output logic                    trip_interrupt_pulse,
  output logic                    cycle_latch_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [SUM_W-1:0]  trip_interrupt_enable;
  logic [SEL_W-1:0]  source_select;
  logic [1:0]        cycle_latch_release_select;
  logic              int_flag;
  logic [SUM_W-1:1]  sum_flags;
  logic [SRC_W-1:0]  cycle_trip_source_flags;
  logic [SRC_W-1:0]  single_trip_source_flags;
  logic [SUM_W-1:0]  trip_summary_flags;

  logic [SUM_W-1:1]  sum_set;
  logic [SUM_W-1:1]  sum_clr;
  logic [SRC_W-1:0]  cyc_set;
  logic [SRC_W-1:0]  cyc_clr;
  logic [SRC_W-1:0]  sgl_set;
  logic [SRC_W-1:0]  sgl_clr;

  logic [9:0]        word_idx;
  logic              setup;
  logic              access;
  logic              wr_en;
  logic              wr_summary_clr;
  logic              wr_cycle_clr;
  logic              wr_single_clr;
  logic              wr_enable;
  logic              wr_select;
  logic [31:0]       next_rdata;
  logic              next_err;

  logic              cycle_any;
  logic              single_any;
  logic              release_evt;
  logic              int_cause;
  logic              int_raise;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign word_idx = paddr[ADDR_W-1:2];
  assign setup    = psel & ~penable;
  assign access   = psel & penable & pready;
  assign wr_en    = access & pwrite & ~pslverr;

  assign wr_summary_clr = wr_en & (word_idx == IDX_SUMMARY_CLEAR);
  assign wr_cycle_clr   = wr_en & (word_idx == IDX_CYCLE_CLEAR);
  assign wr_single_clr  = wr_en & (word_idx == IDX_SINGLE_CLEAR);
  assign wr_enable      = wr_en & (word_idx == IDX_TRIP_ENABLE);
  assign wr_select      = wr_en & (word_idx == IDX_SOURCE_SELECT);

  assign trip_summary_flags = {sum_flags, int_flag};

  // Read data is sampled in the setup cycle; flags changing during the
  // access cycle show on the next read.
  always_comb begin
    next_rdata = RST_RDATA;
    next_err   = 1'b0;
    case (word_idx)
      IDX_TRIP_ENABLE:   next_rdata[SUM_W-1:0] = trip_interrupt_enable;
      IDX_SOURCE_SELECT: next_rdata[SEL_W-1:0] = source_select;
      IDX_SUMMARY_FLAGS: next_rdata[SUM_W-1:0] = trip_summary_flags;
      IDX_CYCLE_FLAGS:   next_rdata[SRC_W-1:0] = cycle_trip_source_flags;
      IDX_SINGLE_FLAGS:  next_rdata[SRC_W-1:0] = single_trip_source_flags;
      IDX_SUMMARY_CLEAR: next_rdata[REL_MSB:REL_LSB] = cycle_latch_release_select; // R14
      IDX_CYCLE_CLEAR:   next_rdata = RST_RDATA; // R16
      IDX_SINGLE_CLEAR:  next_rdata = RST_RDATA;
      default:           next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= RST_RDATA;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (setup) begin
        prdata  <= pwrite ? RST_RDATA : next_rdata;
        pslverr <= next_err;
      end else if (!psel) begin
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_interrupt_enable <= RST_ENABLE;
    end else if (clk_en && wr_enable) begin
      // Bit 0 reserved, reads zero
      trip_interrupt_enable <= {pwdata[SUM_W-1:1], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_select <= RST_SELECT;
    end else if (clk_en && wr_select) begin
      source_select <= pwdata[SEL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_latch_release_select <= RST_RELEASE;
    end else if (clk_en && wr_summary_clr) begin
      cycle_latch_release_select <= pwdata[REL_MSB:REL_LSB]; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip sources

  assign cycle_any  = (|cycle_by_cycle_trip)
                    | (compare_a_event_two & source_select[SEL_DCA2_CBC])
                    | (compare_b_event_two & source_select[SEL_DCB2_CBC]);
  assign single_any = (|one_shot_trip)
                    | (compare_a_event_one & source_select[SEL_DCA1_OST])
                    | (compare_b_event_one & source_select[SEL_DCB1_OST]);

  // Per-source cycle flags
  assign cyc_set = {compare_b_event_two & source_select[SEL_DCB2_CBC],
                    compare_a_event_two & source_select[SEL_DCA2_CBC],
                    cycle_by_cycle_trip}; // R11
  assign cyc_clr = wr_cycle_clr ? pwdata[SRC_W-1:0] : '0; // R16 R13

  // Per-source one-shot flags
  assign sgl_set = {compare_b_event_one & source_select[SEL_DCB1_OST],
                    compare_a_event_one & source_select[SEL_DCA1_OST],
                    one_shot_trip}; // R12
  assign sgl_clr = wr_single_clr ? pwdata[SRC_W-1:0] : '0; // R13

  // Summary flags; bit 0 is handled with the interrupt
  always_comb begin
    sum_set           = '0;
    sum_set[SUM_CBC]  = cycle_any; // R3 R4
    sum_set[SUM_OST]  = single_any; // R2
    sum_set[SUM_DCA1] = compare_a_event_one; // R1
    sum_set[SUM_DCA2] = compare_a_event_two; // R1
    sum_set[SUM_DCB1] = compare_b_event_one; // R1
    sum_set[SUM_DCB2] = compare_b_event_two; // R1
  end

  assign sum_clr = wr_summary_clr ? pwdata[SUM_W-1:1] : '0; // R14 R13

  tzfl_sticky #(
    .WIDTH (SUM_W-1)
  ) u_summary (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .set_in  (sum_set),
    .clr_in  (sum_clr),
    .flags   (sum_flags)
  );

  tzfl_sticky #(
    .WIDTH (SRC_W)
  ) u_cycle (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .set_in  (cyc_set),
    .clr_in  (cyc_clr),
    .flags   (cycle_trip_source_flags)
  );

  tzfl_sticky #(
    .WIDTH (SRC_W)
  ) u_single (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .set_in  (sgl_set),
    .clr_in  (sgl_clr),
    .flags   (single_trip_source_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycle-by-cycle trip latch

  always_comb begin
    case (cycle_latch_release_select)
      REL_ZERO:   release_evt = ctr_zero; // R15
      REL_PERIOD: release_evt = ctr_period; // R15
      REL_EITHER: release_evt = ctr_zero | ctr_period; // R15
      REL_NEVER:  release_evt = 1'b0; // R15
      default:    release_evt = 1'b0;
    endcase
  end

  // Clearing the flag does not release the latch; only the release point
  // does, and a trip still present at that point holds it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_latch_active <= 1'b0;
    end else if (clk_en) begin
      if (cycle_any) begin
        cycle_latch_active <= 1'b1;
      end else if (release_evt) begin
        cycle_latch_active <= 1'b0; // R5 R6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip interrupt

  assign int_cause = |(sum_flags & trip_interrupt_enable[SUM_W-1:1]); // R17 R10
  assign int_raise = int_cause & ~int_flag; // R8 R9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_flag <= 1'b0;
    end else if (clk_en) begin
      if (int_raise) begin
        int_flag <= 1'b1; // R7
      end else if (wr_summary_clr && pwdata[SUM_INT]) begin
        int_flag <= 1'b0; // R14
      end
    end
  end

  // Pulse only with the flag's rise, so a held flag gives no more pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_interrupt_pulse <= 1'b0;
    end else if (clk_en) begin
      // Frozen with the rest of the state while clk_en is low
      trip_interrupt_pulse <= int_raise; // R18 R8
    end
  end

endmodule

`default_nettype wire

// ==== sim/tzfl_partner.sv ====
// Purpose: Time-base counter model beside the trip flag latches
// Assumes: Free-running up count of PERIOD states
// Notes:   Zero and period events are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module tzfl_partner #(
  parameter int PERIOD = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      ctr_zero,
  output logic      ctr_period
);
  logic [7:0] count;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'h00;
    end else begin
      count <= (count == 8'(PERIOD - 1)) ? 8'h00 : count + 8'h01;
    end
  end
  // Quiet in reset so no release event leaks out of it
  assign ctr_zero   = presetn && (count == 8'h00);
  assign ctr_period = presetn && (count == 8'(PERIOD - 1));
endmodule
`default_nettype wire

// ==== sim/tzfl_assertions.sv ====
// Purpose: Port checker for the trip flag latches
// Assumes: clk_en high; release field and clears seen on the bus
// Notes:   Bound into tzfl_top
`timescale 1ns/100ps
`default_nettype none
module tzfl_checker
  import tzfl_pkg::*;
#(
  parameter int SOURCES = SRC_N
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [ADDR_W-1:0]  paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [SOURCES-1:0] cycle_by_cycle_trip,
  input wire logic               compare_a_event_two,
  input wire logic               compare_b_event_two,
  input wire logic               ctr_zero,
  input wire logic               ctr_period,
  input wire logic               trip_interrupt_pulse,
  input wire logic               cycle_latch_active
);
  logic [1:0] rel;
  logic       int_hold;
  wire        clr_hit = psel && penable && pready && pwrite && paddr[11:2] == IDX_SUMMARY_CLEAR;
  wire        mapped  = paddr[11:2] inside {IDX_TRIP_ENABLE, IDX_SOURCE_SELECT, IDX_SUMMARY_FLAGS,
    IDX_CYCLE_FLAGS, IDX_SINGLE_FLAGS, IDX_SUMMARY_CLEAR, IDX_CYCLE_CLEAR, IDX_SINGLE_CLEAR};
  wire        rel_hit = (ctr_zero && !rel[0]) || (ctr_period && (rel[0] ^ rel[1]));
  wire        any_cyc = (|cycle_by_cycle_trip) || compare_a_event_two || compare_b_event_two;
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel <= 2'h0;
    end else if (clr_hit) begin
      rel <= pwdata[15:14];
    end
  end
  // Clear first: a clear may share its edge with the previous pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_hold <= 1'b0;
    end else if (clr_hit && pwdata[0]) begin
      int_hold <= 1'b0;
    end else if (trip_interrupt_pulse) begin
      int_hold <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  pulse_width_a: assert property (trip_interrupt_pulse |=> !trip_interrupt_pulse)
    else $error("interrupt pulse too long");
  int_hold_a: assert property (trip_interrupt_pulse |-> !int_hold)
    else $error("pulse while interrupt flag set");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  slverr_map_a: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("no error for unmapped index");
  latch_set_a: assert property ((|cycle_by_cycle_trip) |=> cycle_latch_active)
    else $error("cycle latch not set");
  latch_hold_a: assert property (cycle_latch_active && !rel_hit |=> cycle_latch_active)
    else $error("cycle latch dropped off release point");
  latch_release_a: assert property (cycle_latch_active && rel_hit && !any_cyc |=> !cycle_latch_active)
    else $error("cycle latch not released");
endmodule
bind tzfl_top tzfl_checker #(.SOURCES(SOURCES)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .cycle_by_cycle_trip, .compare_a_event_two, .compare_b_event_two, .ctr_zero,
  .ctr_period, .trip_interrupt_pulse, .cycle_latch_active);
`default_nettype wire

// ==== sim/tb_trip_zone_flag_latches.sv ====
// Purpose: Self-checking bench for the trip flag latches
// Assumes: clk_en held high, counter period of 8
// Notes:   A monitor checks each read against queued notes
`timescale 1ns/100ps
`default_nettype none
module tb_trip_zone_flag_latches
  import tzfl_pkg::*;
;
  localparam int P = 8;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, ctr_zero, ctr_period, trip_interrupt_pulse, cycle_latch_active;
  logic [5:0]  cycle_by_cycle_trip = 6'h00, one_shot_trip = 6'h00, r;
  logic [3:0]  dc = 4'h0;
  logic [32:0] exp_q[$];
  int          n_mismatch = 0, n_tests = 0, n_pulse = 0, exp_pulse = 0;
  integer      seed = 71566;
  always #50 pclk = ~pclk;
  tzfl_top #(.SOURCES(6)) dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cycle_by_cycle_trip, .one_shot_trip, .compare_a_event_one(dc[0]),
    .compare_a_event_two(dc[1]), .compare_b_event_one(dc[2]), .compare_b_event_two(dc[3]), .ctr_zero,
    .ctr_period, .trip_interrupt_pulse, .cycle_latch_active);
  tzfl_partner #(.PERIOD(P)) u_ctr (.pclk, .presetn, .ctr_zero, .ctr_period);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait for ready has no limit; if ready never comes only the watchdog ends it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [32:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, idx, 32'h0);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (trip_interrupt_pulse === 1'b1) n_pulse++;
    if (psel && penable && pready === 1'b1 && !pwrite) chk_rd({pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    #200000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_CYCLE_FLAGS, 33'h0);
    rd(IDX_SINGLE_FLAGS, 33'h0);
    apb(1'b1, IDX_SUMMARY_FLAGS, 32'hffff);
    rd(IDX_SUMMARY_FLAGS, 33'h0);
    rd(10'h3ff, {1'b1, 32'h0});
    $display("test reset done");
    r = 6'($random(seed)) | 6'h01;
    apb(1'b1, IDX_TRIP_ENABLE, 32'h7e);
    apb(1'b1, IDX_SOURCE_SELECT, 32'hf);
    one_shot_trip <= r;
    dc <= 4'h5;
    @(posedge pclk);
    one_shot_trip <= 6'h00;
    dc <= 4'h0;
    exp_pulse++;
    rd(IDX_SINGLE_FLAGS, {25'h0, 2'b11, r});
    rd(IDX_SUMMARY_FLAGS, 33'h2d);
    apb(1'b1, IDX_SUMMARY_CLEAR, 32'h1);
    exp_pulse++;
    rd(IDX_SUMMARY_CLEAR, 33'h0);
    apb(1'b1, IDX_SINGLE_CLEAR, 32'hff);
    apb(1'b1, IDX_SUMMARY_CLEAR, 32'h7f);
    rd(IDX_SUMMARY_FLAGS, 33'h0);
    rd(IDX_SINGLE_FLAGS, 33'h0);
    chk_val(n_pulse, exp_pulse);
    $display("test one-shot done");
    cycle_by_cycle_trip <= 6'h01;
    dc <= 4'h2;
    exp_pulse++;
    rd(IDX_CYCLE_FLAGS, 33'h41);
    rd(IDX_SUMMARY_FLAGS, 33'h13);
    apb(1'b1, IDX_SUMMARY_CLEAR, 32'h2);
    rd(IDX_SUMMARY_FLAGS, 33'h13);
    cycle_by_cycle_trip <= 6'h00;
    dc <= 4'h0;
    repeat (2 * P) @(posedge pclk);
    chk_val(cycle_latch_active, 32'h0);
    rd(IDX_SUMMARY_FLAGS, 33'h13);
    apb(1'b1, IDX_CYCLE_CLEAR, 32'h01);
    rd(IDX_CYCLE_FLAGS, 33'h40);
    $display("test cycle done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, IDX_SUMMARY_CLEAR, {16'h0, 2'(s), 14'h0});
      rd(IDX_SUMMARY_CLEAR, {17'h0, 2'(s), 14'h0});
      cycle_by_cycle_trip <= 6'h02;
      @(posedge pclk);
      cycle_by_cycle_trip <= 6'h00;
      repeat (2 * P) @(posedge pclk);
      chk_val(cycle_latch_active, {31'h0, s == 3});
    end
    chk_val(n_pulse, exp_pulse);
    $display("test release done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_SUMMARY_CLEAR, 33'h0);
    rd(IDX_SUMMARY_FLAGS, 33'h0);
    chk_val(cycle_latch_active, 32'h0);
    $display("test rerun done");
    // Enables and source select at reset: flags latch, no interrupt
    one_shot_trip <= 6'h04;
    dc <= 4'hf;
    @(posedge pclk);
    one_shot_trip <= 6'h00;
    dc <= 4'h0;
    rd(IDX_SUMMARY_FLAGS, 33'h7c);
    rd(IDX_CYCLE_FLAGS, 33'h0);
    rd(IDX_SINGLE_FLAGS, 33'h04);
    chk_val(n_pulse, exp_pulse);
    apb(1'b1, IDX_TRIP_ENABLE, 32'h04);
    exp_pulse++;
    rd(IDX_SUMMARY_FLAGS, 33'h7d);
    chk_val(n_pulse, exp_pulse);
    $display("test enable done");
    conclude();
  end
endmodule
`default_nettype wire
